// [verilog/pmss_supervisor.sv]
// mode supervisor: power-up mode choice, switch and remote requests, front lamps
// assumes pins and remote request lines are asynchronous and are synchronised here
// retained storage lives outside; this block offers the value and a write strobe
//
// Summary of operation
// - switch run: enter run unless error (power-up enters run even with error), refuse remote
// - switch stop: hold stop, refuse remote
// - switch term: remote may select run/program/test
// - outside term: monitoring only, no edits
// - term without password: full remote access
// - power-up in term resumes last retained mode
// - run select bit with term: power-up run
// - run lamp on run, blink in upgrade
// - diag lamp on error, blink low battery
// - per-port send and receive lamps
// - low battery sets relay flag
// - low battery indication needs setup bit 12
// - fatal error forces program, outputs off
// - outputs enabled only in run mode
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module pmss_supervisor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] mode_switch_in,
	input wire logic remote_req_in,
	input wire logic [1:0] remote_mode_in,
	input wire logic remote_edit_req_in,
	input wire logic password_active_in,
	input wire logic [15:0] setup_word_in,
	input wire logic [1:0] retained_mode_in,
	input wire logic diag_error_in,
	input wire logic fatal_error_in,
	input wire logic battery_low_in,
	input wire logic firmware_upgrade_in,
	input wire logic [1:0] port_send_in,
	input wire logic [1:0] port_receive_in,
	output logic [1:0] mode_out,
	output logic [1:0] retained_mode_out,
	output logic retained_write_out,
	output logic edit_grant_out,
	output logic outputs_enable_out,
	output logic run_lamp_out,
	output logic diag_lamp_out,
	output logic port_one_send_lamp_out,
	output logic port_one_receive_lamp_out,
	output logic port_two_send_lamp_out,
	output logic port_two_receive_lamp_out,
	output logic low_battery_relay_flag_out,
	output logic irq_out
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [pmss_pkg::PMSS_SYNC_W-1:0] sync_a;
	logic [pmss_pkg::PMSS_SYNC_W-1:0] sync_b;
	logic [pmss_pkg::PMSS_SYNC_W-1:0] raw;
	logic [1:0] sw_s;
	logic req_s;
	logic edit_s;
	logic pw_s;
	logic diag_s;
	logic fatal_s;
	logic batt_s;
	logic fwu_s;
	logic [1:0] send_s;
	logic [1:0] recv_s;
	logic [1:0] rmode_s;

	assign raw = {remote_mode_in, port_receive_in, port_send_in, firmware_upgrade_in,
		battery_low_in, fatal_error_in, diag_error_in};

	logic [1:0] sw_a;
	logic [1:0] sw_b;
	logic [2:0] misc_a;
	logic [2:0] misc_b;
	logic [pmss_pkg::PMSS_SYNC_W-1:0] next_sync_a;
	logic [pmss_pkg::PMSS_SYNC_W-1:0] next_sync_b;
	logic [1:0] next_sw_a;
	logic [1:0] next_sw_b;
	logic [2:0] next_misc_a;
	logic [2:0] next_misc_b;
	// the first stage is read only by the second stage
	always_comb begin
		next_sync_a = raw;
		next_sync_b = sync_a;
		next_sw_a = mode_switch_in;
		next_sw_b = sw_a;
		next_misc_a = {remote_req_in, remote_edit_req_in, password_active_in};
		next_misc_b = misc_a;
	end
	// no reset here: the stages keep tracking the pins while reset is held,
	// so the power-up choice sees the switch as it stood before release
	always_ff @(posedge clk_in) begin
		sync_a <= next_sync_a;
		sync_b <= next_sync_b;
		sw_a <= next_sw_a;
		sw_b <= next_sw_b;
		misc_a <= next_misc_a;
		misc_b <= next_misc_b;
	end
	// bit order of the shared stage follows the concatenation above
	assign diag_s = sync_b[0];
	assign fatal_s = sync_b[1];
	assign batt_s = sync_b[2];
	assign fwu_s = sync_b[3];
	assign send_s = sync_b[5:4];
	assign recv_s = sync_b[7:6];
	assign rmode_s = sync_b[9:8];
	assign sw_s = sw_b;
	assign req_s = misc_b[2];
	assign edit_s = misc_b[1];
	assign pw_s = misc_b[0];

	// ----------------------------------------------------------------
	// mode state machine
	// ----------------------------------------------------------------
	pmss_pkg::pmss_state_type state;
	pmss_pkg::pmss_state_type next_state;
	pmss_pkg::pmss_mode_type mode;
	pmss_pkg::pmss_mode_type next_mode;
	logic [1:0] last_mode;
	logic [1:0] next_last_mode;
	logic term_pos;
	logic remote_ok;

	// term_pos and remote_ok gate every remote request
	assign term_pos = (sw_s == pmss_pkg::PMSS_SW_TERM);
	assign remote_ok = term_pos && !pw_s;

	always_comb begin
		next_state = state;
		next_mode = mode;
		case (state)
			pmss_pkg::PMSS_ST_POWERUP: begin
				// one clock only; the switch outranks every stored choice
				next_state = pmss_pkg::PMSS_ST_ACTIVE;
				if (sw_s == pmss_pkg::PMSS_SW_RUN) begin
					next_mode = pmss_pkg::PMSS_MODE_RUN;
				end else if (sw_s == pmss_pkg::PMSS_SW_STOP) begin
					next_mode = pmss_pkg::PMSS_MODE_STOP;
				end else if (setup_word_in[pmss_pkg::PMSS_BIT_PWRUP_RUN]) begin
					next_mode = pmss_pkg::PMSS_MODE_RUN;
				end else begin
					next_mode = pmss_pkg::pmss_mode_type'(retained_mode_in);
				end
			end
			pmss_pkg::PMSS_ST_ACTIVE: begin
				if (sw_s == pmss_pkg::PMSS_SW_RUN) begin
					// error blocks entry to run
					if (!diag_s) begin
						next_mode = pmss_pkg::PMSS_MODE_RUN;
					end
				end else if (sw_s == pmss_pkg::PMSS_SW_STOP) begin
					next_mode = pmss_pkg::PMSS_MODE_STOP;
				end else if (remote_ok && req_s) begin
					// remote requests only count in term without a password
					next_mode = pmss_pkg::pmss_mode_type'(rmode_s);
				end
				// a fatal error overrides everything, the switch included
				if (fatal_s) begin
					next_state = pmss_pkg::PMSS_ST_FAULT;
					next_mode = pmss_pkg::PMSS_MODE_PROGRAM;
				end
			end
			pmss_pkg::PMSS_ST_FAULT: begin
				// stay in program until the fatal cause clears
				next_mode = pmss_pkg::PMSS_MODE_PROGRAM;
				if (!fatal_s) begin
					next_state = pmss_pkg::PMSS_ST_ACTIVE;
				end
			end
			default: begin
				next_state = pmss_pkg::PMSS_ST_POWERUP;
			end
		endcase
		next_last_mode = next_mode;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= pmss_pkg::PMSS_ST_POWERUP;
			mode <= pmss_pkg::PMSS_MODE_PROGRAM;
			last_mode <= 2'h0;
		end else begin
			state <= next_state;
			mode <= next_mode;
			last_mode <= next_last_mode;
		end
	end

	// ----------------------------------------------------------------
	// blink divider
	// ----------------------------------------------------------------
	logic [pmss_pkg::PMSS_CNT_W-1:0] blink_cnt;
	logic [pmss_pkg::PMSS_CNT_W-1:0] next_blink_cnt;
	logic blink;
	logic next_blink;
	// free-running divider; every blinking lamp shares its phase, which
	// keeps the run and diagnostic lamps in step when both blink
	always_comb begin
		next_blink_cnt = blink_cnt + 1'b1;
		next_blink = blink;
		if (blink_cnt == pmss_pkg::PMSS_CNT_W'(pmss_pkg::PMSS_BLINK_CYCLES - 1)) begin
			next_blink_cnt = '0;
			next_blink = !blink;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			blink_cnt <= '0;
			blink <= 1'b0;
		end else begin
			blink_cnt <= next_blink_cnt;
			blink <= next_blink;
		end
	end

	// ----------------------------------------------------------------
	// lamps, flags, edit grant and output enable
	// ----------------------------------------------------------------
	// the lamps follow the synchronised levels and lag their causes by
	// about three clocks, far below anything an eye can see
	logic lowbat_ind;
	logic next_run_lamp;
	logic next_diag_lamp;
	logic next_edit;
	logic next_oe;
	logic next_flag;
	logic [1:0] next_send_lamp;
	logic [1:0] next_receive_lamp;
	assign lowbat_ind = batt_s && setup_word_in[pmss_pkg::PMSS_BIT_LOWBAT_EN];
	always_comb begin
		if (fwu_s) begin
			next_run_lamp = blink;
		end else begin
			next_run_lamp = (mode == pmss_pkg::PMSS_MODE_RUN);
		end
		// a fatal error is a failed self test as well, so it lights the lamp
		if (diag_s || fatal_s) begin
			next_diag_lamp = 1'b1;
		end else begin
			next_diag_lamp = lowbat_ind && blink;
		end
		// monitoring stays possible in every position; only edits are gated
		next_edit = remote_ok && edit_s;
		next_oe = (mode == pmss_pkg::PMSS_MODE_RUN) && (state == pmss_pkg::PMSS_ST_ACTIVE);
		next_flag = batt_s;
		next_send_lamp = send_s;
		next_receive_lamp = recv_s;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			run_lamp_out <= 1'b0;
			diag_lamp_out <= 1'b0;
			edit_grant_out <= 1'b0;
			outputs_enable_out <= 1'b0;
			low_battery_relay_flag_out <= 1'b0;
			port_one_send_lamp_out <= 1'b0;
			port_two_send_lamp_out <= 1'b0;
			port_one_receive_lamp_out <= 1'b0;
			port_two_receive_lamp_out <= 1'b0;
		end else begin
			run_lamp_out <= next_run_lamp;
			diag_lamp_out <= next_diag_lamp;
			edit_grant_out <= next_edit;
			outputs_enable_out <= next_oe;
			low_battery_relay_flag_out <= next_flag;
			port_one_send_lamp_out <= next_send_lamp[0];
			port_two_send_lamp_out <= next_send_lamp[1];
			port_one_receive_lamp_out <= next_receive_lamp[0];
			port_two_receive_lamp_out <= next_receive_lamp[1];
		end
	end
	assign mode_out = mode;

	// ----------------------------------------------------------------
	// retained mode
	// ----------------------------------------------------------------
	// the copy kept over a power loss follows every committed mode; the
	// write strobe is high in the same clock as each new value, so the store only
	// wears on real changes and never while the mode stands still
	logic next_retained_write;
	always_comb begin
		next_retained_write = (next_last_mode != last_mode);
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			retained_write_out <= 1'b0;
		end else begin
			retained_write_out <= next_retained_write;
		end
	end
	assign retained_mode_out = last_mode;

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// no event of this block reaches software through a status register,
	// so the request line is held low
	assign irq_out = 1'b0;
endmodule : pmss_supervisor

// [verilog/pmss_pkg.sv]
// package for the controller mode supervisor: modes, switch codes, timing
// assumes a 20 mhz system clock
package pmss_pkg;
	typedef enum logic [1:0] {
		PMSS_MODE_PROGRAM = 2'b00,
		PMSS_MODE_RUN = 2'b01,
		PMSS_MODE_STOP = 2'b10,
		PMSS_MODE_TEST = 2'b11
	} pmss_mode_type;

	typedef enum logic [1:0] {
		PMSS_SW_STOP = 2'b00,
		PMSS_SW_RUN = 2'b01,
		PMSS_SW_TERM = 2'b10
	} pmss_switch_type;

	typedef enum logic [1:0] {
		PMSS_ST_POWERUP = 2'b00,
		PMSS_ST_ACTIVE = 2'b01,
		PMSS_ST_FAULT = 2'b10
	} pmss_state_type;

	localparam int PMSS_CLK_HZ = 20000000;
	// blink half period in milliseconds
	localparam int PMSS_BLINK_MS = 250;
	localparam int PMSS_BLINK_CYCLES = PMSS_CLK_HZ / 1000 * PMSS_BLINK_MS;
	localparam int PMSS_CNT_W = 24;
	localparam int PMSS_SETUP_W = 16;
	localparam int PMSS_BIT_LOWBAT_EN = 12;
	localparam int PMSS_BIT_PWRUP_RUN = 13;
	localparam int PMSS_PORTS = 2;
	localparam int PMSS_SYNC_W = 10;
endpackage : pmss_pkg

// [tb/pmss_remote_model.sv]
// switch and programming device model: holds the levels the bench commands
// assumes commands change just after a rising edge
`timescale 1ns/10ps
module pmss_remote_model (
	input wire logic clk_in,
	input wire logic [6:0] cmd_in,
	output logic [1:0] switch_out,
	output logic req_out,
	output logic [1:0] mode_out,
	output logic edit_out,
	output logic password_out
);
	logic [6:0] held = 7'h00;
	// one cycle slower than the bench, like a real panel
	always_ff @(posedge clk_in) held <= cmd_in;
	assign {switch_out, req_out, mode_out, edit_out, password_out} = held;
endmodule : pmss_remote_model

// [tb/pmss_checker.sv]
// port assertions for the mode supervisor
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module pmss_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] mode_switch_in,
	input wire logic [15:0] setup_word_in,
	input wire logic diag_error_in,
	input wire logic fatal_error_in,
	input wire logic battery_low_in,
	input wire logic [1:0] port_send_in,
	input wire logic [1:0] port_receive_in,
	input wire logic [1:0] mode_out,
	input wire logic outputs_enable_out,
	input wire logic diag_lamp_out,
	input wire logic port_one_send_lamp_out,
	input wire logic port_one_receive_lamp_out,
	input wire logic port_two_send_lamp_out,
	input wire logic port_two_receive_lamp_out,
	input wire logic low_battery_relay_flag_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	stop_hold_a: assert property ((mode_switch_in == 2'h0 && !fatal_error_in) [*5] |->
		mode_out == 2'h2) else $error("stop lost");
	run_entry_a: assert property ((mode_switch_in == 2'h1 && !diag_error_in &&
		!fatal_error_in) [*5] |-> mode_out == 2'h1) else $error("run missed");
	fatal_prog_a: assert property (fatal_error_in [*5] |->
		mode_out == 2'h0 && !outputs_enable_out) else $error("fatal not program");
	out_run_a: assert property (outputs_enable_out |-> $past(mode_out) == 2'h1)
		else $error("outputs outside run");
	relay_set_a: assert property (battery_low_in [*5] |-> low_battery_relay_flag_out)
		else $error("relay flag missed");
	diag_on_a: assert property (diag_error_in [*5] |-> diag_lamp_out)
		else $error("diag lamp off");
	diag_off_a: assert property ((!diag_error_in && !fatal_error_in &&
		!(battery_low_in && setup_word_in[12])) [*5] |-> !diag_lamp_out)
		else $error("diag lamp on");
	port_lamp_a: assert property ($stable({port_send_in, port_receive_in}) [*5] |->
		{port_two_send_lamp_out, port_one_send_lamp_out, port_two_receive_lamp_out,
		port_one_receive_lamp_out} == {port_send_in, port_receive_in}) else $error("port lamps");
endmodule : pmss_checker
bind pmss_supervisor pmss_checker pmss_checker_inst (.*);

// [tb/plc_mode_status_supervisor_tb.sv]
// bench for the mode supervisor: table of switch and remote steps
// assumes the supervisor, panel model and checker are compiled first
`timescale 1ns/10ps
module plc_mode_status_supervisor_tb;
	logic clk_in = 0, rst_in = 1, remote_req_in, remote_edit_req_in, password_active_in;
	logic [1:0] mode_switch_in, remote_mode_in, retained_mode_in = 0, port_send_in = 0;
	logic [1:0] port_receive_in = 0, mode_out, retained_mode_out;
	logic [15:0] setup_word_in = 0;
	logic diag_error_in = 0, fatal_error_in = 0, battery_low_in = 0, firmware_upgrade_in = 0;
	logic retained_write_out, edit_grant_out, outputs_enable_out, run_lamp_out, diag_lamp_out;
	logic port_one_send_lamp_out, port_one_receive_lamp_out, port_two_send_lamp_out;
	logic port_two_receive_lamp_out, low_battery_relay_flag_out, irq_out, smp = 0;
	logic [6:0] cmd = 0;
	logic [9:0] q[$], e, seen;
	int fails = 0, compares = 0, seed = 32'h5c987bcd;
	initial forever #25 clk_in = ~clk_in;
	pmss_remote_model pmss_remote_model_inst (.clk_in, .cmd_in(cmd), .switch_out(mode_switch_in),
		.req_out(remote_req_in), .mode_out(remote_mode_in), .edit_out(remote_edit_req_in),
		.password_out(password_active_in));
	pmss_supervisor pmss_supervisor_inst (.*);
	assign seen = {mode_out, edit_grant_out, outputs_enable_out, low_battery_relay_flag_out,
		diag_lamp_out, port_two_send_lamp_out, port_one_send_lamp_out, port_two_receive_lamp_out,
		port_one_receive_lamp_out};
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// cmd: switch, request, remote mode, edit, password; x: mode, grant, enable, flag, diag
	task automatic step(input logic [6:0] c, input logic [5:0] x);
		logic [1:0] s, r;
		s = 2'($random(seed));
		r = 2'($random(seed));
		cmd <= c;
		port_send_in <= s;
		port_receive_in <= r;
		repeat (7) @(posedge clk_in);
		q.push_back({x, s, r});
		smp <= 1;
		@(posedge clk_in);
		smp <= 0;
		$display("step %h done", c);
	endtask : step
	task automatic power_up(input logic [15:0] w, input logic [1:0] m, input logic [5:0] x);
		setup_word_in <= w;
		retained_mode_in <= m;
		cmd <= 7'h40;
		rst_in <= 1;
		repeat (5) @(posedge clk_in);
		rst_in <= 0;
		step(7'h40, x);
	endtask : power_up
	always @(negedge clk_in)
		if (smp) begin
			e = q.pop_front();
			compares++;
			if (seen !== e) begin
				fails++;
				$display("unexpected outputs expected %h seen %h", e, seen);
			end
			compares++;
			if (run_lamp_out !== (e[9:8] == 2'h1)) begin
				fails++;
				$display("unexpected run_lamp expected %b seen %b", e[9:8] == 2'h1, run_lamp_out);
			end
			compares++;
			if (retained_mode_out !== e[9:8]) begin
				fails++;
				$display("unexpected retained_mode expected %h seen %h", e[9:8], retained_mode_out);
			end
			compares++;
			if (irq_out !== 1'b0) begin
				fails++;
				$display("unexpected irq expected 0 seen %b", irq_out);
			end
		end
	initial begin
		#20000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 0;
		step(7'h16, 6'h20);
		step(7'h32, 6'h14);
		diag_error_in <= 1;
		step(7'h00, 6'h21);
		step(7'h20, 6'h21);
		diag_error_in <= 0;
		step(7'h56, 6'h1c);
		step(7'h5e, 6'h38);
		step(7'h5a, 6'h28);
		step(7'h52, 6'h08);
		step(7'h57, 6'h00);
		fatal_error_in <= 1;
		step(7'h20, 6'h01);
		fatal_error_in <= 0;
		battery_low_in <= 1;
		step(7'h20, 6'h16);
		battery_low_in <= 0;
		power_up(16'h2000, 2'h0, 6'h14);
		power_up(16'h0000, 2'h3, 6'h30);
		print_verdict();
	end
endmodule : plc_mode_status_supervisor_tb
